// ===== i2m_baud.sv
/*
  Reload-and-halt baud counter with its own quarter-cycle phase.
  Assumes sys_clk is four phases per instruction cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module i2m_baud
  import i2m_pkg::*;
#(
  parameter int CNT_W = RELOAD_W
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  // Control from and status to the engine
  input  wire i2m_baud_ctl_t ctl,
  output i2m_baud_sts_t      sts
);
  if (CNT_W != RELOAD_W) begin : g_chk
    $error("i2m_baud: CNT_W must equal RELOAD_W");
  end

  typedef struct packed {
    logic [1:0]       phase;
    logic [CNT_W-1:0] cnt;
  } i2m_baud_regs_t;

  i2m_baud_regs_t q;
  i2m_baud_regs_t d;

  always_comb begin
    d = q;
    d.phase = q.phase + 2'h1;
    if (ctl.load) begin
      d.cnt = ctl.reload;
    end else if ((q.phase == PH_Q2 || q.phase == PH_Q4) && q.cnt != '0) begin
      d.cnt = q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sts.cnt_zero = (q.cnt == '0);
  assign sts.phase    = q.phase;
endmodule // i2m_baud
`default_nettype wire

// ===== i2m_master.sv
/*
  I2C master transmit engine with arbitration, behind an APB slave.
  Assumes open-drain SDA/SCL with external pull-ups; line inputs are
  asynchronous and are synchronised here.
*/
// The APB interface to the registers was left to the implementer.
// Summary of operation
// - Baud counter reloads from low seven bits of the reload register.
// - Baud counter counts down to zero, then halts until reloaded.
// - Counter decrements twice per instruction cycle, on two quarter phases.
// - Reload is automatic; while SCL is stretched it reloads until SCL high.
// - Writing the shift buffer sets buffer full and starts the transfer.
// - SDA changes in the cycle SCL is pulled low; SCL low then high one baud period each.
// - On eighth falling edge clear buffer full and release SDA.
// - Ninth falling edge samples SDA into the acknowledge status bit.
// - After ninth clock set serial flag, hold SCL low until next write.
// - Address phase sends seven address bits and direction bit, then ACK.
// - Buffer write while shifting is ignored and sets write collision.
// - Released SDA seen low while SCL high is a bus collision, go idle.
// - Data collision halts, clears buffer full, releases lines, allows writes.
// - Start or stop collision aborts, releases lines, clears request bits.
// - After collision, a STOP seen on the bus sets the serial flag.
// - After collision, a new write transmits from the first bit.
// - STOP: SDA low, release SCL, count once high, then check SDA.
// - During STOP, SCL low before SDA is released is a collision.
// - Stop request bit starts STOP; serial flag set when it completes.
`timescale 1ns/100ps
`default_nettype none
module i2m_master
  import i2m_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // I2C lines
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  i2m_regs_t     q;
  i2m_regs_t     d;
  i2m_baud_ctl_t bctl;
  i2m_baud_sts_t bsts;

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_IRQ_FLAGS || a == OFF_IRQ_EN || a == OFF_RELOAD ||
           a == OFF_BUF || a == OFF_STATUS || a == OFF_CTL2 || a == OFF_ERR;
  endfunction

  i2m_baud #(
    .CNT_W (RELOAD_W)
  ) u_baud (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ctl     (bctl),
    .sts     (bsts)
  );

  always_comb begin
    logic wr;
    logic acc;
    logic coll;
    logic scl_h;
    logic sda_h;
    logic timeout;
    logic start_ev;
    logic stop_ev;
    d        = q;
    wr       = 1'b0;
    acc      = 1'b0;
    coll     = 1'b0;
    bctl.load   = 1'b0;
    bctl.reload = q.reload[RELOAD_W-1:0];
    // Only the second and third stages are looked at
    d.scl_s  = {q.scl_s[1:0], scl_i};
    d.sda_s  = {q.sda_s[1:0], sda_i};
    scl_h    = q.scl_s[1];
    sda_h    = q.sda_s[1];
    timeout  = bsts.cnt_zero;
    start_ev = scl_h & q.scl_s[2] & q.sda_s[2] & ~sda_h;
    stop_ev  = scl_h & q.scl_s[2] & ~q.sda_s[2] & sda_h;

    // APB: one wait state, answer on the second access edge
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped(paddr);
      d.prdata  = 32'h0000_0000;
      unique case (paddr)
        OFF_IRQ_FLAGS: d.prdata[7:0] = q.irq_flags;
        OFF_IRQ_EN:    d.prdata[7:0] = q.irq_en;
        OFF_RELOAD:    d.prdata[7:0] = q.reload;
        OFF_BUF:       d.prdata[7:0] = q.buffer;
        OFF_STATUS: begin
          d.prdata[ST_FULL_BIT]  = q.full;
          d.prdata[ST_START_BIT] = q.start_seen;
          d.prdata[ST_STOP_BIT]  = q.stop_seen;
        end
        OFF_CTL2: begin
          d.prdata[CTL2_START_BIT] = q.start_req;
          d.prdata[CTL2_STOP_BIT]  = q.stop_req;
          d.prdata[CTL2_ACK_BIT]   = q.ack_stat;
        end
        OFF_ERR: begin
          d.prdata[ERR_WRITE_COLLISION_FLAG_BIT] = q.write_collision_flag;
          d.prdata[ERR_BCOL_BIT] = q.bcol;
        end
        default: d.prdata = 32'h0000_0000;
      endcase
    end
    acc = psel && penable && q.pready;
    wr  = acc && pwrite && mapped(paddr);

    // Software writes first; hardware sets below win over clears
    if (wr) begin
      unique case (paddr)
        OFF_IRQ_FLAGS: d.irq_flags = pwdata[7:0];
        OFF_IRQ_EN:    d.irq_en    = pwdata[7:0];
        OFF_RELOAD:    d.reload    = pwdata[7:0];
        OFF_CTL2: begin
          d.start_req = pwdata[CTL2_START_BIT];
          d.stop_req  = pwdata[CTL2_STOP_BIT];
        end
        OFF_ERR: begin
          d.write_collision_flag = pwdata[ERR_WRITE_COLLISION_FLAG_BIT];
          d.bcol = pwdata[ERR_BCOL_BIT];
        end
        OFF_BUF: begin
          if (q.state != ST_IDLE && q.state != ST_WAIT) begin
            d.write_collision_flag = 1'b1;
          end else begin
            // Idle or paused: always restart at the first bit
            d.buffer    = pwdata[7:0];
            d.sr        = pwdata[7:0];
            d.bitcnt    = 4'h0;
            d.full      = 1'b1;
            d.scl_oe    = 1'b1;
            d.sda_oe    = ~pwdata[7];
            d.state     = ST_LOW;
            bctl.load   = 1'b1;
          end
        end
        default: d.state = q.state;
      endcase
    end

    // Bus condition tracking for free-bus decisions
    if (start_ev) begin
      d.start_seen = 1'b1;
      d.stop_seen  = 1'b0;
    end
    if (stop_ev) begin
      d.stop_seen  = 1'b1;
      d.start_seen = 1'b0;
      if (q.watch) begin
        d.irq_flags[IRQ_SERIAL_BIT] = 1'b1;
        d.watch = 1'b0;
      end
    end

    unique case (q.state)
      ST_IDLE: begin
        if (q.start_req && !d.full) begin
          if (!sda_h || !scl_h) begin
            coll = 1'b1;
          end else begin
            d.sda_oe  = 1'b1;
            d.state   = ST_START;
            bctl.load = 1'b1;
          end
        end
      end
      ST_START: begin
        // Another master holding SCL low aborts the start
        if (!scl_h) begin
          coll = 1'b1;
        end else if (timeout) begin
          d.scl_oe    = 1'b1;
          d.start_req = 1'b0;
          d.irq_flags[IRQ_SERIAL_BIT] = 1'b1;
          d.state     = ST_WAIT;
        end
      end
      ST_LOW: begin
        if (timeout) begin
          d.scl_oe = 1'b0;
          d.state  = ST_HIGH;
          bctl.load = 1'b1;
        end
      end
      ST_HIGH: begin
        // Counting starts only once SCL is really high
        if (!scl_h) begin
          bctl.load = 1'b1;
        end else if (!q.sda_oe && q.bitcnt != ACK_BIT && !sda_h) begin
          coll = 1'b1;
        end else if (timeout) begin
          d.scl_oe = 1'b1;
          if (q.bitcnt == ACK_BIT) begin
            d.ack_stat = sda_h;
            d.irq_flags[IRQ_SERIAL_BIT] = 1'b1;
            d.state = ST_WAIT;
          end else begin
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == LAST_BIT) begin
              d.full   = 1'b0;
              d.sda_oe = 1'b0;
            end else begin
              d.sr     = {q.sr[6:0], 1'b0};
              d.sda_oe = ~q.sr[6];
            end
            d.state   = ST_LOW;
            bctl.load = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // Baud counter stays halted here with SCL held low
        if (q.stop_req && q.state == d.state) begin
          d.sda_oe  = 1'b1;
          d.state   = ST_STOP1;
          bctl.load = 1'b1;
        end
      end
      ST_STOP1: begin
        if (timeout) begin
          d.scl_oe      = 1'b0;
          d.scl_hi_seen = 1'b0;
          d.state       = ST_STOP2;
          bctl.load     = 1'b1;
        end
      end
      ST_STOP2: begin
        if (!scl_h) begin
          bctl.load = 1'b1;
          if (q.scl_hi_seen) begin
            coll = 1'b1;
          end
        end else begin
          d.scl_hi_seen = 1'b1;
          if (timeout && q.scl_hi_seen) begin
            d.sda_oe  = 1'b0;
            d.state   = ST_STOP3;
            bctl.load = 1'b1;
          end
        end
      end
      ST_STOP3: begin
        if (!scl_h && !sda_h) begin
          coll = 1'b1;
        end else if (timeout) begin
          if (!sda_h) begin
            coll = 1'b1;
          end else begin
            d.stop_req = 1'b0;
            d.irq_flags[IRQ_SERIAL_BIT] = 1'b1;
            d.state    = ST_IDLE;
          end
        end
      end
    endcase

    // Collision: give up the bus, keep watching for its release
    if (coll) begin
      d.bcol      = 1'b1;
      d.full      = 1'b0;
      d.start_req = 1'b0;
      d.stop_req  = 1'b0;
      d.scl_oe    = 1'b0;
      d.sda_oe    = 1'b0;
      d.watch     = 1'b1;
      d.state     = ST_IDLE;
      bctl.load   = 1'b0;
    end
    d.line_lvl = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= RST_REGS;
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign scl_o   = q.line_lvl;
  assign scl_oe  = q.scl_oe;
  assign sda_o   = q.line_lvl;
  assign sda_oe  = q.sda_oe;
endmodule // i2m_master
`default_nettype wire

// ===== i2m_master_properties.sv
/* Port checker for i2m_master, bound onto every instance.
   Assumes the APB master keeps the request stable until pready. */
`timescale 1ns/100ps
`default_nettype none
module i2m_master_properties
  import i2m_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // I2C lines
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  logic [6:0]  rl_q;
  logic [15:0] hi_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Reload snooped from the bus, so the low-time bound follows software
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rl_q <= RST_RELOAD[6:0];
      hi_q <= 16'h0000;
    end else begin
      if (psel && penable && pready && pwrite && paddr == OFF_RELOAD) begin
        rl_q <= pwdata[6:0];
      end
      hi_q <= scl_oe ? hi_q + 16'h0001 : 16'h0000;
    end
  end
  property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_req; pready |-> psel && penable; endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("pready outside access");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_low_only; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_low_only: assert property (p_low_only) else $error("line driven high");
  property p_sep; $fell(scl_oe) |-> $stable(sda_oe); endproperty
  a_sep: assert property (p_sep) else $error("sda moved at scl release");
  // Slack of two cycles covers the free-running phase counter
  property p_scl_low;
    scl_oe ##1 !scl_oe |-> hi_q + 16'h0002 >= {8'h00, rl_q, 1'b0};
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low too short");
  property p_rst; $rose(reset_n) |-> !scl_oe && !sda_oe && !pready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  c_err: cover property (pslverr);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_clk: cover property ($rose(scl_oe));
endmodule // i2m_master_properties

bind i2m_master i2m_master_properties u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

// ===== i2m_master_tb.sv
/* Self-checking bench for i2m_master with a slave model.
   Assumes pull-ups on both lines and a single APB master. */
`timescale 1ns/100ps
`default_nettype none
module i2m_master_tb
  import i2m_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        ack_en = 1'b1;
  logic        coll_en = 1'b0;
  logic        stretch_en = 1'b0;
  logic [31:0] prdata, rd_v;
  logic        err_v = 1'b0;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe;
  logic        scl_d = 1'b1;
  logic [8:0]  cap = 9'h000;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  wire logic   scl_w = !(scl_oe || s_scl_oe);
  wire logic   sda_w = !(sda_oe || s_sda_oe);
  always #5 sys_clk = ~sys_clk;
  i2m_master dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  i2m_slave_model u_slave (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_i(scl_w), .sda_i(sda_w),
    .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .ack_en(ack_en), .coll_en(coll_en),
    .stretch_en(stretch_en)
  );
  // Last nine bits seen at SCL rises; timeout ceiling
  always @(posedge sys_clk) begin
    scl_d <= scl_w;
    if (scl_w && !scl_d) cap <= {cap[7:0], sda_w};
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench ceiling ends this wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd_v);
  endtask
  task automatic rdb(input logic [7:0] a, input int b, input logic e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, {31'h0, e}, {31'h0, rd_v[b]});
  endtask
  // Polls a flag under a bounded count
  task automatic wbit(input logic [7:0] a, input int b, input string nm);
    int k;
    rd_v = 32'h0000_0000;
    for (k = 0; k < 300 && rd_v[b] !== 1'b1; k++) apb(1'b0, a, 32'h0000_0000);
    chk(nm, 32'h0000_0001, {31'h0, rd_v[b]});
  endtask
  task automatic srv;
    wbit(OFF_IRQ_FLAGS, IRQ_SERIAL_BIT, "serial flag");
    apb(1'b1, OFF_IRQ_FLAGS, 32'h0000_0000);
  endtask
  task automatic start_bus;
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk("bus free", 32'h0000_0001, {31'h0, rd_v[ST_STOP_BIT] | ~rd_v[ST_START_BIT]});
    apb(1'b1, OFF_CTL2, 32'h1 << CTL2_START_BIT);
    srv;
  endtask
  task automatic t_regs;
    rd(OFF_IRQ_FLAGS, 32'h0000_0000, "irq flags reset");
    rd(OFF_IRQ_EN, 32'h0000_0000, "irq enables reset");
    rd(OFF_RELOAD, {24'h0, RST_RELOAD}, "reload reset");
    apb(1'b1, OFF_IRQ_EN, 32'h0000_00A5);
    rd(OFF_IRQ_EN, 32'h0000_00A5, "irq enables rw");
    apb(1'b1, OFF_RELOAD, 32'h0000_0083);
    rd(OFF_RELOAD, 32'h0000_0083, "reload rw");
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err_v});
    chk("unmapped data", 32'h0000_0000, rd_v);
  endtask
  task automatic t_byte;
    start_bus;
    apb(1'b1, OFF_BUF, 32'h0000_00A6);
    rdb(OFF_STATUS, ST_FULL_BIT, 1'b1, "full while shifting");
    apb(1'b1, OFF_BUF, 32'h0000_003C);
    srv;
    chk("address byte", 32'h0000_00A6, {24'h0, cap[8:1]});
    chk("ack on wire", 32'h0000_0000, {31'h0, cap[0]});
    rdb(OFF_CTL2, CTL2_ACK_BIT, 1'b0, "ack status");
    rdb(OFF_STATUS, ST_FULL_BIT, 1'b0, "full after byte");
    rdb(OFF_ERR, ERR_WRITE_COLLISION_FLAG_BIT, 1'b1, "write collision");
    rd(OFF_BUF, 32'h0000_00A6, "buffer kept");
    apb(1'b1, OFF_ERR, 32'h0000_0000);
    rdb(OFF_ERR, ERR_WRITE_COLLISION_FLAG_BIT, 1'b0, "collision cleared");
    chk("scl held", 32'h0000_0001, {31'h0, scl_oe});
    ack_en <= 1'b0;
    stretch_en <= 1'b1;
    apb(1'b1, OFF_BUF, 32'h0000_005C);
    srv;
    chk("stretched byte", 32'h0000_005C, {24'h0, cap[8:1]});
    chk("sda released", 32'h0000_0001, {31'h0, cap[0]});
    rdb(OFF_CTL2, CTL2_ACK_BIT, 1'b1, "no ack status");
    ack_en <= 1'b1;
    stretch_en <= 1'b0;
  endtask
  task automatic t_stop;
    apb(1'b1, OFF_CTL2, 32'h1 << CTL2_STOP_BIT);
    srv;
    rdb(OFF_CTL2, CTL2_STOP_BIT, 1'b0, "stop request");
    chk("lines after stop", 32'h0000_0003, {30'h0, scl_w, sda_w});
    rdb(OFF_STATUS, ST_STOP_BIT, 1'b1, "stop seen");
  endtask
  task automatic t_coll;
    start_bus;
    coll_en <= 1'b1;
    apb(1'b1, OFF_BUF, 32'h0000_000F);
    wbit(OFF_ERR, ERR_BCOL_BIT, "bus collision");
    rdb(OFF_STATUS, ST_FULL_BIT, 1'b0, "full after collision");
    chk("lines released", 32'h0000_0000, {30'h0, scl_oe, sda_oe});
    apb(1'b1, OFF_IRQ_FLAGS, 32'h0000_0000);
    coll_en <= 1'b0;
    srv;
    apb(1'b1, OFF_ERR, 32'h0000_0000);
    coll_en <= 1'b1;
    apb(1'b1, OFF_CTL2, 32'h1 << CTL2_START_BIT);
    wbit(OFF_ERR, ERR_BCOL_BIT, "start collision");
    rdb(OFF_CTL2, CTL2_START_BIT, 1'b0, "start request dropped");
    apb(1'b1, OFF_IRQ_FLAGS, 32'h0000_0000);
    coll_en <= 1'b0;
    srv;
    apb(1'b1, OFF_ERR, 32'h0000_0000);
    start_bus;
    apb(1'b1, OFF_BUF, 32'h0000_005A);
    srv;
    chk("byte after collision", 32'h0000_005A, {24'h0, cap[8:1]});
    rdb(OFF_ERR, ERR_WRITE_COLLISION_FLAG_BIT, 1'b0, "write accepted");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs;
    t_byte;
    t_stop;
    t_coll;
    t_stop;
    close_out;
  end
endmodule // i2m_master_tb
`default_nettype wire

// ===== i2m_pkg.sv
/*
  Shared constants and types for the I2C master transmit engine:
  register offsets, field positions, reset values and state codes.
  Assumes a 32-bit APB slave port with byte addresses.
*/
`default_nettype none
package i2m_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h8C;
  localparam logic [7:0] OFF_RELOAD    = 8'h10;
  localparam logic [7:0] OFF_BUF       = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_CTL2      = 8'h1C;
  localparam logic [7:0] OFF_ERR       = 8'h20;

  // Field positions
  localparam int IRQ_SERIAL_BIT = 3;
  localparam int ST_FULL_BIT    = 0;
  localparam int ST_START_BIT   = 3;
  localparam int ST_STOP_BIT    = 4;
  localparam int CTL2_START_BIT = 0;
  localparam int CTL2_STOP_BIT  = 2;
  localparam int CTL2_ACK_BIT   = 6;
  localparam int ERR_WRITE_COLLISION_FLAG_BIT   = 0;
  localparam int ERR_BCOL_BIT   = 1;

  // Widths and counts
  localparam int          RELOAD_W = 7;
  localparam logic [3:0]  ACK_BIT  = 4'h8;
  localparam logic [3:0]  LAST_BIT = 4'h7;
  localparam logic [1:0]  PH_Q2    = 2'h1;
  localparam logic [1:0]  PH_Q4    = 2'h3;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_RELOAD = 8'h09;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_LOW   = 3'h3,
    ST_HIGH  = 3'h2,
    ST_WAIT  = 3'h6,
    ST_STOP1 = 3'h7,
    ST_STOP2 = 3'h5,
    ST_STOP3 = 3'h4
  } i2m_state_t;

  typedef struct packed {
    logic                load;
    logic [RELOAD_W-1:0] reload;
  } i2m_baud_ctl_t;

  typedef struct packed {
    logic                cnt_zero;
    logic [1:0]          phase;
  } i2m_baud_sts_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  irq_flags;
    logic [7:0]  irq_en;
    logic [7:0]  reload;
    logic [7:0]  buffer;
    logic [7:0]  sr;
    logic [3:0]  bitcnt;
    i2m_state_t  state;
    logic        full;
    logic        write_collision_flag;
    logic        bcol;
    logic        ack_stat;
    logic        start_req;
    logic        stop_req;
    logic        start_seen;
    logic        stop_seen;
    logic        watch;
    logic        scl_hi_seen;
    logic        scl_oe;
    logic        sda_oe;
    logic        line_lvl;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
  } i2m_regs_t;

  localparam i2m_regs_t RST_REGS = '{
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
    irq_flags: RST_BYTE, irq_en: RST_BYTE, reload: RST_RELOAD,
    buffer: RST_BYTE, sr: RST_BYTE, bitcnt: 4'h0, state: ST_IDLE,
    full: 1'b0, write_collision_flag: 1'b0, bcol: 1'b0, ack_stat: 1'b0,
    start_req: 1'b0, stop_req: 1'b0, start_seen: 1'b0,
    stop_seen: 1'b0, watch: 1'b0, scl_hi_seen: 1'b0,
    scl_oe: 1'b0, sda_oe: 1'b0, line_lvl: 1'b0,
    scl_s: 3'h7, sda_s: 3'h7
  };
endpackage : i2m_pkg
`default_nettype wire

// ===== i2m_slave_model.sv
/* Behavioural I2C slave and rival master on the far side.
   Assumes wired-AND lines with pull-ups made by the bench. */
`timescale 1ns/100ps
`default_nettype none
module i2m_slave_model (
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  reset_n,
  // Bus lines
  input wire logic  scl_i,
  input wire logic  sda_i,
  output logic      scl_oe,
  output logic      sda_oe,
  // Bench controls
  input wire logic  ack_en,
  input wire logic  coll_en,
  input wire logic  stretch_en
);
  logic       scl_q;
  logic       sda_q;
  logic       ack_q;
  logic [3:0] cnt_q;
  logic [5:0] st_q;
  assign sda_oe = ack_q || coll_en;
  assign scl_oe = st_q != 6'h00;
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (!reset_n) begin
      cnt_q <= 4'hF;
      ack_q <= 1'b0;
      st_q <= 6'h00;
    end else begin
      if (st_q != 6'h00) st_q <= st_q - 6'h01;
      // Start: the fall that follows is not a bit
      if (scl_i && scl_q && sda_q && !sda_i) begin
        cnt_q <= 4'hF;
      end else if (scl_q && !scl_i) begin
        if (stretch_en) st_q <= 6'h1E;
        cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
        ack_q <= ack_en && cnt_q == 4'h7;
      end
    end
  end
endmodule // i2m_slave_model
`default_nettype wire
